// [csia_core_sfr.sv]
// Core SFR bank on APB with indirect data memory views through pointer zero
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module csia_core_sfr #(
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input  wire logic              CLK_I,
    input  wire logic              SYS_RST_I,
    // APB slave
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic                   PREADY_O,
    output logic [31:0]            PRDATA_O,
    output logic                   PSLVERR_O,
    // Stack top entry from the stack logic
    input  wire logic [20:0]       STACK_TOP_ENTRY_I,
    // Data memory port
    output logic                   MEM_REQ_O,
    output logic                   MEM_WE_O,
    output logic [11:0]            MEM_ADDR_O,
    output logic [7:0]             MEM_WDATA_O,
    input  wire logic              MEM_ACK_I,
    input  wire logic [7:0]        MEM_RDATA_I,
    // Table pointer view
    output logic [21:0]            TABLE_INDEX_O,
    // Pointer zero view
    output logic [11:0]            POINTER_ZERO_O
);
    typedef struct packed {
        logic [7:0]           stack_top_low;
        logic [7:0]           ret_stack_idx;
        logic [7:0]           pc_upper;
        logic [7:0]           pc_high;
        logic [7:0]           pc_low;
        logic [7:0]           tbl_upper;
        logic [7:0]           tbl_high;
        logic [7:0]           tbl_low;
        logic [7:0]           tbl_latch;
        logic [7:0]           mult_high;
        logic [7:0]           mult_low;
        logic [7:0]           irq_main;
        logic [7:0]           irq_edges;
        logic [7:0]           irq_ext;
        logic [11:0]          ptr0;
        csia_pkg::csia_mstate_t mstate;
        logic                 mem_req;
        logic                 mem_we;
        logic [11:0]          mem_addr;
        logic [7:0]           mem_wdata;
        logic                 ready;
        logic [31:0]          rdata;
        logic                 slverr;
    } csia_state_t;

    csia_state_t st_r;
    csia_state_t st_nxt;

    // ==========================================================
    // Decode
    logic [11:0] idx;
    logic        setup;
    logic        is_view;
    logic        hit;
    assign idx   = PADDR_I[13:2];
    assign setup = PSEL_I && PENABLE_I && !st_r.ready;
    assign is_view = (idx == csia_pkg::IDX_INDIRECT_PLAIN)
                  || (idx == csia_pkg::IDX_INDIRECT_POST_UP)
                  || (idx == csia_pkg::IDX_INDIRECT_POST_DN)
                  || (idx == csia_pkg::IDX_INDIRECT_PRE_UP);
    always_comb begin
        hit = 1'b1;
        case (idx)
            csia_pkg::IDX_STACK_TOP_UPPER, csia_pkg::IDX_STACK_TOP_HIGH,
            csia_pkg::IDX_STACK_TOP_LOW, csia_pkg::IDX_RETURN_STACK_IDX,
            csia_pkg::IDX_PC_UPPER_HOLD, csia_pkg::IDX_PC_HIGH_HOLD,
            csia_pkg::IDX_PC_LOW_BYTE, csia_pkg::IDX_TABLE_UPPER,
            csia_pkg::IDX_TABLE_HIGH, csia_pkg::IDX_TABLE_LOW,
            csia_pkg::IDX_TABLE_LATCH, csia_pkg::IDX_MULT_HIGH,
            csia_pkg::IDX_MULT_LOW, csia_pkg::IDX_IRQ_MAIN,
            csia_pkg::IDX_IRQ_EDGES, csia_pkg::IDX_IRQ_EXTERNAL,
            csia_pkg::IDX_INDIRECT_PLAIN, csia_pkg::IDX_INDIRECT_POST_UP,
            csia_pkg::IDX_INDIRECT_POST_DN, csia_pkg::IDX_INDIRECT_PRE_UP,
            csia_pkg::IDX_POINTER_ZERO_HIGH, csia_pkg::IDX_POINTER_ZERO_LOW: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ==========================================================
    // Read mux for plain registers
    logic [7:0] rd_byte;
    always_comb begin
        case (idx)
            csia_pkg::IDX_STACK_TOP_UPPER:
                rd_byte = {3'h0, STACK_TOP_ENTRY_I[20:16]};
            csia_pkg::IDX_STACK_TOP_HIGH:   rd_byte = STACK_TOP_ENTRY_I[15:8];
            csia_pkg::IDX_STACK_TOP_LOW:    rd_byte = st_r.stack_top_low;
            csia_pkg::IDX_RETURN_STACK_IDX: rd_byte = st_r.ret_stack_idx;
            csia_pkg::IDX_PC_UPPER_HOLD:    rd_byte = st_r.pc_upper;
            csia_pkg::IDX_PC_HIGH_HOLD:     rd_byte = st_r.pc_high;
            csia_pkg::IDX_PC_LOW_BYTE:      rd_byte = st_r.pc_low;
            csia_pkg::IDX_TABLE_UPPER:      rd_byte = st_r.tbl_upper;
            csia_pkg::IDX_TABLE_HIGH:       rd_byte = st_r.tbl_high;
            csia_pkg::IDX_TABLE_LOW:        rd_byte = st_r.tbl_low;
            csia_pkg::IDX_TABLE_LATCH:      rd_byte = st_r.tbl_latch;
            csia_pkg::IDX_MULT_HIGH:        rd_byte = st_r.mult_high;
            csia_pkg::IDX_MULT_LOW:         rd_byte = st_r.mult_low;
            csia_pkg::IDX_IRQ_MAIN:         rd_byte = st_r.irq_main;
            csia_pkg::IDX_IRQ_EDGES:        rd_byte = st_r.irq_edges;
            csia_pkg::IDX_IRQ_EXTERNAL:     rd_byte = st_r.irq_ext;
            csia_pkg::IDX_POINTER_ZERO_HIGH: rd_byte = {4'h0, st_r.ptr0[11:8]};
            csia_pkg::IDX_POINTER_ZERO_LOW: rd_byte = st_r.ptr0[7:0];
            default:                        rd_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // Next state
    logic [7:0] wb;
    assign wb = PWDATA_I[7:0];
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ready = 1'b0;
        case (st_r.mstate)
            csia_pkg::MS_IDLE: begin
                if (setup && (!hit || !is_view)) begin
                    st_nxt.ready  = 1'b1;
                    st_nxt.slverr = !hit;
                    st_nxt.rdata  = PWRITE_I ? 32'h0 : {24'h0, rd_byte};
                    if (PWRITE_I && hit) begin
                        case (idx)
                            csia_pkg::IDX_STACK_TOP_LOW:  st_nxt.stack_top_low = wb;
                            csia_pkg::IDX_RETURN_STACK_IDX:
                                st_nxt.ret_stack_idx = (st_r.ret_stack_idx
                                    & csia_pkg::RETSTK_KEEP_MASK)
                                    | (wb & csia_pkg::RETSTK_WR_MASK);
                            csia_pkg::IDX_PC_UPPER_HOLD:
                                st_nxt.pc_upper = {2'h0, wb[csia_pkg::PC_UPPER_W-1:0]};
                            csia_pkg::IDX_PC_HIGH_HOLD:   st_nxt.pc_high = wb;
                            csia_pkg::IDX_PC_LOW_BYTE:    st_nxt.pc_low = wb;
                            csia_pkg::IDX_TABLE_UPPER:
                                st_nxt.tbl_upper = {2'h0, wb[csia_pkg::TABLE_UPPER_W-1:0]};
                            csia_pkg::IDX_TABLE_HIGH:     st_nxt.tbl_high = wb;
                            csia_pkg::IDX_TABLE_LOW:      st_nxt.tbl_low = wb;
                            csia_pkg::IDX_TABLE_LATCH:    st_nxt.tbl_latch = wb;
                            csia_pkg::IDX_MULT_HIGH:      st_nxt.mult_high = wb;
                            csia_pkg::IDX_MULT_LOW:       st_nxt.mult_low = wb;
                            csia_pkg::IDX_IRQ_MAIN:       st_nxt.irq_main = wb;
                            csia_pkg::IDX_IRQ_EDGES:      st_nxt.irq_edges = wb;
                            csia_pkg::IDX_IRQ_EXTERNAL:   st_nxt.irq_ext = wb;
                            csia_pkg::IDX_POINTER_ZERO_HIGH:
                                st_nxt.ptr0[11:8] = wb[csia_pkg::POINTER_HIGH_W-1:0];
                            csia_pkg::IDX_POINTER_ZERO_LOW: st_nxt.ptr0[7:0] = wb;
                            default: st_nxt.slverr = 1'b0;
                        endcase
                    end
                end else if (setup) begin
                    // Views hold no storage; the access goes to data memory
                    st_nxt.mstate    = csia_pkg::MS_WAIT;
                    st_nxt.mem_req   = 1'b1;
                    st_nxt.mem_we    = PWRITE_I;
                    st_nxt.mem_wdata = wb;
                    st_nxt.slverr    = 1'b0;
                    st_nxt.mem_addr  = st_r.ptr0;
                    if (idx == csia_pkg::IDX_INDIRECT_PRE_UP) begin
                        st_nxt.mem_addr = st_r.ptr0 + 12'h001;
                        st_nxt.ptr0     = st_r.ptr0 + 12'h001;
                    end
                end
            end
            csia_pkg::MS_WAIT: begin
                if (MEM_ACK_I) begin
                    st_nxt.mem_req = 1'b0;
                    st_nxt.mstate  = csia_pkg::MS_IDLE;
                    st_nxt.ready   = 1'b1;
                    st_nxt.rdata   = st_r.mem_we ? 32'h0 : {24'h0, MEM_RDATA_I};
                    // Single step per access, taken on the same edge as ready so the next sees it
                    if (idx == csia_pkg::IDX_INDIRECT_POST_UP)
                        st_nxt.ptr0 = st_r.ptr0 + 12'h001;
                    else if (idx == csia_pkg::IDX_INDIRECT_POST_DN)
                        st_nxt.ptr0 = st_r.ptr0 - 12'h001;
                end
            end
            default: st_nxt.mstate = csia_pkg::MS_IDLE;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            st_r               <= '0;
            st_r.mstate        <= csia_pkg::MS_IDLE;
            st_r.stack_top_low <= csia_pkg::RST_ZERO;
            st_r.pc_upper      <= csia_pkg::RST_ZERO;
            st_r.pc_high       <= csia_pkg::RST_ZERO;
            st_r.pc_low        <= csia_pkg::RST_ZERO;
            st_r.tbl_upper     <= csia_pkg::RST_ZERO;
            st_r.tbl_latch     <= csia_pkg::RST_ZERO;
            st_r.irq_edges     <= csia_pkg::RST_IRQ_EDGES;
            st_r.irq_ext       <= csia_pkg::RST_IRQ_EXTERNAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign PREADY_O       = st_r.ready;
    assign PRDATA_O       = st_r.rdata;
    assign PSLVERR_O      = st_r.slverr && st_r.ready;
    assign MEM_REQ_O      = st_r.mem_req;
    assign MEM_WE_O       = st_r.mem_we;
    assign MEM_ADDR_O     = st_r.mem_addr;
    assign MEM_WDATA_O    = st_r.mem_wdata;
    assign TABLE_INDEX_O  = {st_r.tbl_upper[5:0], st_r.tbl_high, st_r.tbl_low};
    assign POINTER_ZERO_O = st_r.ptr0;
endmodule

// [csia_pkg.sv]
// Constants for the core SFR bank with indirect views of pointer zero
package csia_pkg;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [11:0] IDX_STACK_TOP_UPPER   = 12'hfff;
    localparam logic [11:0] IDX_STACK_TOP_HIGH    = 12'hffe;
    localparam logic [11:0] IDX_STACK_TOP_LOW     = 12'hffd;
    localparam logic [11:0] IDX_RETURN_STACK_IDX  = 12'hffc;
    localparam logic [11:0] IDX_PC_UPPER_HOLD     = 12'hffb;
    localparam logic [11:0] IDX_PC_HIGH_HOLD      = 12'hffa;
    localparam logic [11:0] IDX_PC_LOW_BYTE       = 12'hff9;
    localparam logic [11:0] IDX_TABLE_UPPER       = 12'hff8;
    localparam logic [11:0] IDX_TABLE_HIGH        = 12'hff7;
    localparam logic [11:0] IDX_TABLE_LOW         = 12'hff6;
    localparam logic [11:0] IDX_TABLE_LATCH       = 12'hff5;
    localparam logic [11:0] IDX_MULT_HIGH         = 12'hff4;
    localparam logic [11:0] IDX_MULT_LOW          = 12'hff3;
    localparam logic [11:0] IDX_IRQ_MAIN          = 12'hff2;
    localparam logic [11:0] IDX_IRQ_EDGES         = 12'hff1;
    localparam logic [11:0] IDX_IRQ_EXTERNAL      = 12'hff0;
    localparam logic [11:0] IDX_INDIRECT_PLAIN    = 12'hfef;
    localparam logic [11:0] IDX_INDIRECT_POST_UP  = 12'hfee;
    localparam logic [11:0] IDX_INDIRECT_POST_DN  = 12'hfed;
    localparam logic [11:0] IDX_INDIRECT_PRE_UP   = 12'hfec;
    localparam logic [11:0] IDX_POINTER_ZERO_HIGH = 12'hfea;
    localparam logic [11:0] IDX_POINTER_ZERO_LOW  = 12'hfe9;
    // ==========================================================
    // Field layout and reset values
    localparam int          STACK_TOP_UPPER_W  = 5;
    localparam int          PC_UPPER_W         = 6;
    localparam int          TABLE_UPPER_W      = 6;
    localparam int          POINTER_W          = 12;
    localparam int          POINTER_HIGH_W     = 4;
    localparam logic [7:0]  RST_ZERO           = 8'h00;
    localparam logic [7:0]  RST_IRQ_EDGES      = 8'hff;
    localparam logic [7:0]  RST_IRQ_EXTERNAL   = 8'hc0;
    localparam logic [7:0]  RETSTK_KEEP_MASK   = 8'hc0;
    localparam logic [7:0]  RETSTK_WR_MASK     = 8'h1f;
    localparam logic [7:0]  IRQ_MAIN_RST_MASK  = 8'h01;
    // ==========================================================
    // Memory side states
    typedef enum logic [1:0] {
        MS_IDLE,
        MS_WAIT
    } csia_mstate_t;
endpackage

// [csia_sfr_assertions.sv]
// Port checks for the core SFR bank
`timescale 1ns/1ps
module csia_sfr_chk #(
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input wire logic              CLK_I,
    input wire logic              SYS_RST_I,
    // APB side
    input wire logic              PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0]       PWDATA_I,
    input wire logic              PREADY_O,
    input wire logic [31:0]       PRDATA_O,
    input wire logic              PSLVERR_O,
    // Core side
    input wire logic [20:0]       STACK_TOP_ENTRY_I,
    input wire logic              MEM_REQ_O,
    input wire logic [11:0]       MEM_ADDR_O,
    input wire logic              MEM_ACK_I,
    input wire logic [21:0]       TABLE_INDEX_O,
    input wire logic [11:0]       POINTER_ZERO_O
);
    logic [11:0] idx;
    logic        done;
    logic        rd_ok;
    assign idx   = PADDR_I[ADDR_W-1:2];
    assign done  = MEM_REQ_O && MEM_ACK_I;
    assign rd_ok = PREADY_O && !PWRITE_I && !PSLVERR_O;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // ==========================================================
    // Answer timing
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    ack_ready_a: assert property (done |=> PREADY_O)
        else $error("no ready after memory ack");
    req_hold_a: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O))
        else $error("memory request dropped or moved");
    // ==========================================================
    // Register contents
    upper_view_a: assert property (rd_ok && idx == csia_pkg::IDX_STACK_TOP_UPPER
        |-> PRDATA_O == {27'h0, $past(STACK_TOP_ENTRY_I[20:16])})
        else $error("stack top upper wrong");
    high_view_a: assert property (rd_ok && idx == csia_pkg::IDX_STACK_TOP_HIGH
        |-> PRDATA_O == {24'h0, $past(STACK_TOP_ENTRY_I[15:8])})
        else $error("stack top high wrong");
    table_high_a: assert property (PREADY_O && PWRITE_I && idx == csia_pkg::IDX_TABLE_HIGH
        |=> TABLE_INDEX_O[15:8] == $past(PWDATA_I[7:0]))
        else $error("table high not written");
    table_low_a: assert property (PREADY_O && PWRITE_I && idx == csia_pkg::IDX_TABLE_LOW
        |=> TABLE_INDEX_O[7:0] == $past(PWDATA_I[7:0]))
        else $error("table low not written");
    // ==========================================================
    // Pointer zero views
    view_addr_a: assert property ($rose(MEM_REQ_O) |-> MEM_ADDR_O == POINTER_ZERO_O)
        else $error("view address not pointer zero");
    plain_keep_a: assert property (done && idx == csia_pkg::IDX_INDIRECT_PLAIN
        |=> POINTER_ZERO_O == $past(MEM_ADDR_O))
        else $error("plain view moved pointer");
    post_up_a: assert property (done && idx == csia_pkg::IDX_INDIRECT_POST_UP
        |=> POINTER_ZERO_O == 12'($past(MEM_ADDR_O) + 12'h001))
        else $error("post-up step wrong");
    post_down_a: assert property (done && idx == csia_pkg::IDX_INDIRECT_POST_DN
        |=> POINTER_ZERO_O == 12'($past(MEM_ADDR_O) - 12'h001))
        else $error("post-down step wrong");
    pre_up_a: assert property ($rose(MEM_REQ_O) && idx == csia_pkg::IDX_INDIRECT_PRE_UP
        |-> MEM_ADDR_O == 12'($past(POINTER_ZERO_O) + 12'h001))
        else $error("pre-up address wrong");
    cover property (done && idx == csia_pkg::IDX_INDIRECT_POST_UP);
    cover property ($rose(MEM_REQ_O) && idx == csia_pkg::IDX_INDIRECT_PRE_UP);
    cover property (PSLVERR_O);
endmodule

// [csia_tb.sv]
// Testbench for the core SFR bank
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [13:0] padr = 14'h0;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic        prdy, perr, er, mreq, mwe, ack = 1'b0;
    logic [11:0] madr, pz, s_adr;
    logic [7:0]  mwd, rdat = 8'h00, s_wd;
    logic [1:0]  mcnt = 2'h0;
    logic [21:0] tix;
    logic [20:0] ent = 21'h1b5a3c;
    int          mismatches = 0, check_count = 0, cyc = 0;
    csia_core_sfr csia_core_sfr_i (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PREADY_O(prdy),
        .PRDATA_O(prd), .PSLVERR_O(perr), .STACK_TOP_ENTRY_I(ent), .MEM_REQ_O(mreq),
        .MEM_WE_O(mwe), .MEM_ADDR_O(madr), .MEM_WDATA_O(mwd), .MEM_ACK_I(ack),
        .MEM_RDATA_I(rdat), .TABLE_INDEX_O(tix), .POINTER_ZERO_O(pz));
    always #2 clk = ~clk;
    // ==========================================================
    // Data memory: answers after three cycles, data toggles in every cycle it is not answering
    always @(posedge clk) begin
        if (mreq && !ack && mcnt == 2'h2) begin
            ack <= 1'b1;
            rdat <= ~madr[7:0];
            mcnt <= 2'h0;
            s_adr <= madr;
            s_wd <= mwe ? mwd : 8'h00;
        end else begin
            ack <= 1'b0;
            rdat <= ~rdat;
            if (mreq && !ack) begin
                mcnt <= mcnt + 2'h1;
            end
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            close_out();
        end
    end
    // ==========================================================
    // APB access: waits for ready, no fixed latency assumed
    task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= {i, 2'h0};
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Pointer starts at 1ff so the views cross the byte carry
    logic [11:0] vix[5] = '{csia_pkg::IDX_INDIRECT_PLAIN, csia_pkg::IDX_INDIRECT_POST_UP,
        csia_pkg::IDX_INDIRECT_POST_DN, csia_pkg::IDX_INDIRECT_PRE_UP,
        csia_pkg::IDX_INDIRECT_POST_DN};
    logic [11:0] vad[5] = '{12'h1ff, 12'h1ff, 12'h200, 12'h200, 12'h200};
    logic [11:0] vpz[5] = '{12'h1ff, 12'h200, 12'h1ff, 12'h200, 12'h1ff};
    logic        vwr[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, csia_pkg::IDX_IRQ_EDGES, 8'h00);
        chk(rd, 32'hff);
        apb(1'b0, csia_pkg::IDX_IRQ_EXTERNAL, 8'h00);
        chk(rd, 32'hc0);
        apb(1'b1, csia_pkg::IDX_STACK_TOP_UPPER, 8'hff);
        apb(1'b0, csia_pkg::IDX_STACK_TOP_UPPER, 8'h00);
        chk(rd, {27'h0, ent[20:16]});
        apb(1'b0, csia_pkg::IDX_STACK_TOP_HIGH, 8'h00);
        chk(rd, {24'h0, ent[15:8]});
        apb(1'b1, csia_pkg::IDX_TABLE_HIGH, 8'ha5);
        apb(1'b1, csia_pkg::IDX_TABLE_LOW, 8'h5a);
        chk({16'h0, tix[15:0]}, 32'ha55a);
        apb(1'b0, csia_pkg::IDX_TABLE_HIGH, 8'h00);
        chk(rd, 32'ha5);
        // Unmapped place answers with error and zero
        apb(1'b0, 12'hfe0, 8'h00);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'b1, csia_pkg::IDX_POINTER_ZERO_HIGH, 8'h01);
        apb(1'b1, csia_pkg::IDX_POINTER_ZERO_LOW, 8'hff);
        for (int k = 0; k < 5; k++) begin
            apb(vwr[k], vix[k], 8'h3c);
            chk({20'h0, s_adr}, {20'h0, vad[k]});
            chk({20'h0, pz}, {20'h0, vpz[k]});
            chk(vwr[k] ? {24'h0, s_wd} : rd, {24'h0, vwr[k] ? 8'h3c : ~vad[k][7:0]});
        end
        close_out();
    end
endmodule
bind csia_core_sfr csia_sfr_chk #(.ADDR_W(ADDR_W)) csia_sfr_chk_i (.CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
    .STACK_TOP_ENTRY_I(STACK_TOP_ENTRY_I), .MEM_REQ_O(MEM_REQ_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_ACK_I(MEM_ACK_I), .TABLE_INDEX_O(TABLE_INDEX_O), .POINTER_ZERO_O(POINTER_ZERO_O));
